// File: src/adc_seq_pkg.sv
// constants shared by the conversion sequencer and its result formatter
// assumes a single 100 MHz clock domain and a byte-level serial front end
package adc_seq_pkg;

	// ****************************************************************
	// clock and widths
	// ****************************************************************
	localparam int CLOCK_MHZ = 100;            // system clock rate
	localparam int RAW_W     = 20;             // filter output width
	localparam int CODE_W    = 16;             // result code width
	localparam int FRAC_DROP = 2;              // raw lsbs below one code step

	// ****************************************************************
	// register pointers
	// ****************************************************************
	localparam logic [7:0] PTR_RESULT = 8'h00; // result register
	localparam logic [7:0] PTR_CONFIG = 8'h01; // configuration register

	// ****************************************************************
	// configuration register layout and reset value
	// ****************************************************************
	localparam int CFG_FLAG     = 15;          // start / ready flag
	localparam int CFG_GAIN_HI  = 11;          // gain field msb
	localparam int CFG_GAIN_LO  = 9;           // gain field lsb
	localparam int CFG_MODE     = 8;           // 1 = single shot
	localparam logic [15:0] CFG_DEFAULT = 16'h8500;

	// ****************************************************************
	// write byte sequence positions
	// ****************************************************************
	localparam logic [1:0] WB_POINTER = 2'h0;  // pointer byte
	localparam logic [1:0] WB_MSB     = 2'h1;  // data high byte
	localparam logic [1:0] WB_LSB     = 2'h2;  // data low byte
	localparam logic [1:0] WB_EXTRA   = 2'h3;  // surplus bytes

	// ****************************************************************
	// gain codes and full-scale ranges in millivolts
	// ****************************************************************
	localparam logic [2:0] GAIN_2_3 = 3'h0;
	localparam logic [2:0] GAIN_1   = 3'h1;
	localparam logic [2:0] GAIN_2   = 3'h2;
	localparam logic [2:0] GAIN_4   = 3'h3;
	localparam logic [2:0] GAIN_8   = 3'h4;
	localparam logic [15:0] FS_6144 = 16'h1800;
	localparam logic [15:0] FS_4096 = 16'h1000;
	localparam logic [15:0] FS_2048 = 16'h0800;
	localparam logic [15:0] FS_1024 = 16'h0400;
	localparam logic [15:0] FS_512  = 16'h0200;
	localparam logic [15:0] FS_256  = 16'h0100;

	// ****************************************************************
	// saturation codes
	// ****************************************************************
	localparam logic [15:0] CODE_POS_MAX = 16'h7FFF;
	localparam logic [15:0] CODE_NEG_MAX = 16'h8000;

	// ****************************************************************
	// sequencer states, gray along idle -> convert
	// ****************************************************************
	typedef enum logic [0:0] {
		ST_IDLE    = 1'b0,
		ST_CONVERT = 1'b1
	} seq_state_t;

endpackage

// File: src/result_formatter.sv
// saturating two's complement formatter for one conversion result
// assumes raw input is scaled so that full scale equals 2**17 raw lsbs
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// formatter
// ****************************************************************
module result_formatter (
	// filter value
	input  wire logic signed [19:0] raw,
	// formatted code
	output logic         [15:0] code
);

	logic signed [17:0] steps;  // raw value in whole code steps
	logic               over;   // above positive full scale
	logic               under;  // below negative full scale

	// drop sub-step bits, then clip at the two end codes
	always_comb begin
		steps = 18'(raw >>> adc_seq_pkg::FRAC_DROP);           // see R10
		over  = !steps[17] && (steps[16:15] != 2'h0);
		under = steps[17] && (steps[16:15] != 2'h3);
		if (over) begin
			code = adc_seq_pkg::CODE_POS_MAX;                   // see R9
		end else if (under) begin
			code = adc_seq_pkg::CODE_NEG_MAX;
		end else begin
			code = steps[15:0];
		end
	end

endmodule

`default_nettype wire

// File: src/adc_conversion_sequencer.sv
// conversion sequencer: mode control, start/ready flag, gain select,
// result capture and the byte-level register access of the serial link
// assumes the serial engine and the analog core run on this same clock
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: continuous mode stores result, restarts at once
// R2: single shot idles powered down until flag
// R3: flag reads zero while converting
// R4: single shot sets flag then powers down
// R5: start write during conversion is ignored
// R6: power-up reset restores configuration defaults
// R7: general call reset equals power-up reset
// R8: result is sixteen-bit two's complement
// R9: result saturates at 7FFF and 8000
// R10: one code step is full scale over 2^15
// R11: six gains from 2/3 to 16
// R12: three-bit field selects gain and range
// R13: gainless variant fixed at 2.048 V
// R14: host alone picks duty-cycle interval
// R15: pointer byte then two data bytes, msb first
// R16: reads return msb then lsb
// R17: result updated no later than flag
module adc_conversion_sequencer #(
	parameter bit HAS_GAIN = 1'b1               // 0 = variant without gain stage
) (
	// clock, reset, enable
	input  wire logic              clock,
	input  wire logic              srst,
	input  wire logic              ce,
	// serial engine side
	input  wire logic              gc_reset,      // general call reset, pulse
	input  wire logic              xfer_start,    // start of a transaction, pulse
	input  wire logic              wr_byte_valid, // received byte, pulse
	input  wire logic [7:0]        wr_byte,
	input  wire logic              rd_byte_req,   // byte to send, pulse
	output logic      [7:0]        rd_byte,
	// analog core side
	input  wire logic              conv_done,     // filter result ready, pulse
	input  wire logic signed [19:0] conv_raw,
	output logic                   core_power,
	output logic                   core_start,
	output logic      [2:0]        input_gain_stage,
	output logic      [15:0]       full_scale_range,
	// status
	output logic                   conversion_start_ready_flag,
	output logic      [15:0]       result
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		adc_seq_pkg::seq_state_t state;   // sequencer state
		logic [15:0]             cfg;     // configuration register
		logic [15:0]             result;  // result register
		logic                    ptr_cfg; // pointer selects configuration
		logic [1:0]              wr_pos;  // byte position in a write
		logic [7:0]              wr_msb;  // held high data byte
		logic                    rd_lsb;  // next read byte is the low one
		logic [7:0]              rd_byte; // byte for the serial engine
		logic                    start;   // start pulse to the core
	} seq_t;

	localparam seq_t SEQ_RESET = '{
		state:   adc_seq_pkg::ST_IDLE,
		cfg:     adc_seq_pkg::CFG_DEFAULT,
		result:  16'h0000,
		ptr_cfg: 1'b0,
		wr_pos:  adc_seq_pkg::WB_POINTER,
		wr_msb:  8'h00,
		rd_lsb:  1'b0,
		rd_byte: 8'h00,
		start:   1'b0
	};

	seq_t        s;          // registered state
	seq_t        next_s;     // next state
	logic [15:0] code;       // formatted conversion value
	logic        commit;     // configuration write completes
	logic        start_req;  // write asks for a single conversion
	logic        cont_mode;  // continuous after this cycle's write
	logic [15:0] rd_word;    // register the pointer selects
	logic [2:0]  gain_code;  // raw gain field

	// ****************************************************************
	// result formatting
	// ****************************************************************
	result_formatter u_fmt (
		.raw  (conv_raw),
		.code (code)
	);

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	// register writes first, then the conversion sequence on the result
	always_comb begin
		next_s    = s;
		next_s.start = 1'b0;
		commit    = 1'b0;
		start_req = 1'b0;
		rd_word   = s.ptr_cfg ? s.cfg : s.result;

		// a new transaction restarts byte counting
		if (xfer_start) begin
			next_s.wr_pos = adc_seq_pkg::WB_POINTER;
			next_s.rd_lsb = 1'b0;
		end

		// write bytes: pointer, high, low
		if (wr_byte_valid) begin
			case (s.wr_pos)
				adc_seq_pkg::WB_POINTER: begin
					next_s.ptr_cfg = (wr_byte == adc_seq_pkg::PTR_CONFIG); // see R15
					next_s.rd_lsb  = 1'b0;
					next_s.wr_pos  = adc_seq_pkg::WB_MSB;
				end
				adc_seq_pkg::WB_MSB: begin
					next_s.wr_msb = wr_byte;                               // see R15
					next_s.wr_pos = adc_seq_pkg::WB_LSB;
				end
				adc_seq_pkg::WB_LSB: begin
					commit        = s.ptr_cfg;  // result register is read-only
					next_s.wr_pos = adc_seq_pkg::WB_EXTRA;
				end
				default: begin
					next_s.wr_pos = adc_seq_pkg::WB_EXTRA; // surplus ignored
				end
			endcase
		end

		// the flag bit is never stored from a write: it only requests
		if (commit) begin
			next_s.cfg = {s.cfg[adc_seq_pkg::CFG_FLAG], s.wr_msb[6:0], wr_byte};
			start_req  = s.wr_msb[7];
		end
		cont_mode = !next_s.cfg[adc_seq_pkg::CFG_MODE];

		// conversion sequence
		case (s.state)
			adc_seq_pkg::ST_IDLE: begin
				// powered down until asked, or free running in continuous
				if (cont_mode || start_req) begin                  // see R2
					next_s.state = adc_seq_pkg::ST_CONVERT;
					next_s.start = 1'b1;
					next_s.cfg[adc_seq_pkg::CFG_FLAG] = 1'b0;      // see R3
				end
			end
			adc_seq_pkg::ST_CONVERT: begin
				// start_req is dropped here: no restart, no queue     see R5
				next_s.cfg[adc_seq_pkg::CFG_FLAG] = 1'b0;          // see R3
				if (conv_done) begin
					next_s.result = code;                          // see R8 R17
					if (cont_mode) begin
						next_s.start = 1'b1;                       // see R1
					end else begin
						next_s.state = adc_seq_pkg::ST_IDLE;       // see R4
						next_s.cfg[adc_seq_pkg::CFG_FLAG] = 1'b1;  // see R4
					end
				end
			end
			default: begin
				next_s.state = adc_seq_pkg::ST_IDLE;
			end
		endcase

		// read bytes: high first, then low, then alternate
		if (rd_byte_req) begin
			next_s.rd_byte = s.rd_lsb ? rd_word[7:0] : rd_word[15:8]; // see R16
			next_s.rd_lsb  = !s.rd_lsb;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	// general call reset acts exactly as power-up reset, even with ce low
	always_ff @(posedge clock) begin
		if (srst || gc_reset) begin
			s <= SEQ_RESET;                                        // see R6 R7
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// gain and full-scale range
	// ****************************************************************
	// the gainless variant ignores the field; codes above 4 read as 16
	always_comb begin
		gain_code = s.cfg[adc_seq_pkg::CFG_GAIN_HI:adc_seq_pkg::CFG_GAIN_LO];
		input_gain_stage = HAS_GAIN ? gain_code : adc_seq_pkg::GAIN_2; // see R12 R13
		case (input_gain_stage)
			adc_seq_pkg::GAIN_2_3: full_scale_range = adc_seq_pkg::FS_6144; // see R11
			adc_seq_pkg::GAIN_1:   full_scale_range = adc_seq_pkg::FS_4096;
			adc_seq_pkg::GAIN_2:   full_scale_range = adc_seq_pkg::FS_2048;
			adc_seq_pkg::GAIN_4:   full_scale_range = adc_seq_pkg::FS_1024;
			adc_seq_pkg::GAIN_8:   full_scale_range = adc_seq_pkg::FS_512;
			default:               full_scale_range = adc_seq_pkg::FS_256;
		endcase
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign core_power = (s.state == adc_seq_pkg::ST_CONVERT);
	assign core_start = s.start;
	assign rd_byte    = s.rd_byte;
	assign result     = s.result;
	assign conversion_start_ready_flag = s.cfg[adc_seq_pkg::CFG_FLAG];

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst || gc_reset || !ce);

	logic cont_now;   // continuous mode as registered
	assign cont_now = !s.cfg[adc_seq_pkg::CFG_MODE];

	chk_cont_restart: assert property ( // see R1
		core_power && conv_done && cont_now && !wr_byte_valid
		|=> core_start && core_power && result == $past(code))
		else $error("continuous conversion did not restart");

	chk_single_idle: assert property ( // see R2
		!core_power && !cont_now && !wr_byte_valid |=> !core_power)
		else $error("single shot left idle without request");

	chk_flag_busy: assert property ( // see R3
		core_power |-> !conversion_start_ready_flag)
		else $error("flag high during conversion");

	chk_flag_return: assert property ( // see R4 R17
		core_power && conv_done && !cont_now && !wr_byte_valid
		|=> conversion_start_ready_flag && !core_power && result == $past(code))
		else $error("single shot end handled wrongly");

	chk_busy_ignore: assert property ( // see R5
		core_power && !conv_done |=> !core_start)
		else $error("start accepted during conversion");

	chk_reset_cfg: assert property (@(posedge clock) disable iff (1'b0) // see R6 R7
		srst || gc_reset |=> s.cfg == adc_seq_pkg::CFG_DEFAULT && !core_power)
		else $error("reset did not restore configuration");

	chk_saturate: assert property ( // see R9
		core_power && conv_done && conv_raw[19:17] == 3'h1
		|=> result == adc_seq_pkg::CODE_POS_MAX)
		else $error("positive overrange not clipped");

	chk_fixed_range: assert property ( // see R13
		!HAS_GAIN |-> full_scale_range == adc_seq_pkg::FS_2048)
		else $error("gainless range not fixed");

	chk_read_order: assert property ( // see R16
		rd_byte_req && !s.rd_lsb ##1 rd_byte_req && !xfer_start && !wr_byte_valid
		|=> rd_byte == $past(rd_word[7:0], 1) && $past(rd_byte) == $past(rd_word[15:8], 2))
		else $error("read byte order wrong");

	cov_continuous: cover property (core_power && conv_done && cont_now ##1 core_start);
	cov_single_end: cover property (core_power && conv_done && !cont_now ##1 !core_power);
	cov_ignored: cover property (core_power && commit && start_req);

endmodule

`default_nettype wire

// File: tb/analog_core_model.sv
// behavioural model of the analog core and filter behind the sequencer
// assumes core_start is a one-cycle pulse on the shared 100 MHz clock
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// core model
// ****************************************************************
module analog_core_model (
	// clock
	input  wire logic               clock,
	// control from the sequencer
	input  wire logic               core_start,
	// scenario knobs
	input  wire logic        [15:0] lat,
	input  wire logic signed [19:0] raw_in,
	// filter result
	output logic                    conv_done,
	output logic signed [19:0]      conv_raw
);
	logic               busy = 1'b0;   // conversion running
	logic               done = 1'b0;   // result pulse
	logic signed [19:0] held = '0;     // value on the result lines
	int                 cnt  = 0;      // cycles left

	// one result per start; lines toggle outside the done cycle
	always @(posedge clock) begin
		done <= 1'b0;
		if (core_start) begin
			busy <= 1'b1;
			cnt  <= lat;
		end else if (busy && cnt <= 1) begin
			busy <= 1'b0;
			done <= 1'b1;
			held <= raw_in;
		end else begin
			cnt  <= cnt - 1;
			held <= ~held;    // no stale value between results
		end
	end
	assign conv_done = done;
	assign conv_raw  = held;
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the conversion sequencer
// assumes the analog core model answers each core_start after lat cycles
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// bench top
// ****************************************************************
module testbench;
	// stimulus
	logic clock, srst, ce, gc_reset, xfer_start, wr_byte_valid, rd_byte_req;
	logic [7:0]         wr_byte;
	logic [15:0]        lat;
	logic signed [19:0] raw_in;
	// observed
	logic [7:0]         rd_byte;
	logic               conv_done, core_power, core_start, flag;
	logic signed [19:0] conv_raw;
	logic [2:0]         gain, gain0;
	logic [15:0]        fs, fs0, result, v;
	int                 n_fail, checks_done, starts, s0, i;

	adc_conversion_sequencer DUT (.clock(clock), .srst(srst), .ce(ce),
		.gc_reset(gc_reset), .xfer_start(xfer_start), .wr_byte_valid(wr_byte_valid),
		.wr_byte(wr_byte), .rd_byte_req(rd_byte_req), .rd_byte(rd_byte),
		.conv_done(conv_done), .conv_raw(conv_raw), .core_power(core_power),
		.core_start(core_start), .input_gain_stage(gain), .full_scale_range(fs),
		.conversion_start_ready_flag(flag), .result(result));
	// gainless variant on the same stimulus, only its gain and range are watched
	adc_conversion_sequencer #(.HAS_GAIN(1'b0)) DUT_fixed (.clock(clock), .srst(srst),
		.ce(ce), .gc_reset(gc_reset), .xfer_start(xfer_start),
		.wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .rd_byte_req(rd_byte_req),
		.rd_byte(), .conv_done(conv_done), .conv_raw(conv_raw), .core_power(),
		.core_start(), .input_gain_stage(gain0), .full_scale_range(fs0),
		.conversion_start_ready_flag(), .result());
	analog_core_model core (.clock(clock), .core_start(core_start), .lat(lat),
		.raw_in(raw_in), .conv_done(conv_done), .conv_raw(conv_raw));

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// count start pulses as they happen
	always @(posedge clock) begin
		if (core_start === 1'b1) starts++;
	end

	task automatic tick;
		@(posedge clock);
		#1;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// pointer byte then data msb, lsb; ends in the cycle after the lsb
	task automatic wcfg(input logic [15:0] d);
		xfer_start = 1'b1;
		tick;
		xfer_start = 1'b0;
		wr_byte_valid = 1'b1;
		wr_byte = 8'h01;
		tick;
		wr_byte = d[15:8];
		tick;
		wr_byte = d[7:0];
		tick;
		wr_byte_valid = 1'b0;
	endtask
	// select a register, then read msb and lsb
	task automatic rd(input logic [7:0] p, output logic [15:0] d);
		xfer_start = 1'b1;
		tick;
		xfer_start = 1'b0;
		wr_byte_valid = 1'b1;
		wr_byte = p;
		tick;
		wr_byte_valid = 1'b0;
		rd_byte_req = 1'b1;
		tick;
		d[15:8] = rd_byte;
		tick;
		d[7:0] = rd_byte;
		rd_byte_req = 1'b0;
	endtask
	task automatic wait_flag;
		for (i = 0; i < 300 && flag !== 1'b1; i++) tick;
		if (flag !== 1'b1) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	// one single-shot conversion, result compared when the flag returns
	task automatic one_shot(input logic signed [19:0] r, input logic [15:0] code);
		raw_in = r;
		wcfg(16'h8300);
		check(flag, 1'b0);
		check(core_power, 1'b1);
		wait_flag();
		check(result, code);
		tick;
		check(core_power, 1'b0);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{srst, gc_reset, xfer_start, wr_byte_valid, rd_byte_req} = 5'h10;
		ce = 1'b1;
		wr_byte = 8'h00;
		lat = 16'h0005;
		raw_in = '0;
		n_fail = 0;
		checks_done = 0;
		starts = 0;
		repeat (12) tick;
		srst = 1'b0;
		// power-up defaults, read msb first
		rd(8'h01, v);
		check(v, 16'h8500);
		check(core_power, 1'b0);
		// codes around zero and both saturation ends
		one_shot(20'sh00004, 16'h0001);
		one_shot(-20'sh00004, 16'hFFFF);
		one_shot(20'sh00000, 16'h0000);
		one_shot(20'sh20000, 16'h7FFF);
		one_shot(-20'sh20004, 16'h8000);
		one_shot(-20'sh09ABC, 16'hD951);
		rd(8'h00, v);
		check(v, 16'hD951);
		// start request while converting is dropped
		lat = 16'h0028;
		s0 = starts;
		raw_in = 20'sh00010;
		wcfg(16'h8300);
		repeat (5) tick;
		wcfg(16'h8300);
		wait_flag();
		repeat (50) tick;
		check(starts - s0, 1);
		// every gain code, no conversion requested
		for (int g = 0; g < 8; g++) begin
			wcfg({4'h0, g[2:0], 9'h100});
			check(gain, g[2:0]);
			check(gain0, 3'h2);
			check(fs0, 16'h0800);
			case (g)
				0: check(fs, 16'h1800);
				1: check(fs, 16'h1000);
				2: check(fs, 16'h0800);
				3: check(fs, 16'h0400);
				4: check(fs, 16'h0200);
				default: check(fs, 16'h0100);
			endcase
		end
		// clock enable low freezes all state, so this request is lost
		ce = 1'b0;
		wcfg(16'h8300);
		ce = 1'b1;
		check(core_power, 1'b0);
		check(gain, 3'h7);
		// continuous mode restarts on its own, flag stays low
		lat = 16'h0003;
		raw_in = 20'sh00008;
		s0 = starts;
		wcfg(16'h0400);
		repeat (30) tick;
		check(result, 16'h0002);
		check(flag, 1'b0);
		check(starts - s0 >= 4, 1'b1);
		wcfg(16'h0500);
		wait_flag();
		// general call reset in mid conversion
		lat = 16'h0032;
		wcfg(16'h8700);
		gc_reset = 1'b1;
		tick;
		gc_reset = 1'b0;
		check(core_power, 1'b0);
		rd(8'h01, v);
		check(v, 16'h8500);
		tally_and_finish();
	end
endmodule
`default_nettype wire
